// ---- tkr_params.svh ----
// Constants for the timekeeping RAM block
`ifndef TKR_PARAMS_SVH
`define TKR_PARAMS_SVH
`define TKR_ADDR_W 19
`define TKR_RAM_DEPTH 524288
`define TKR_OFS_CENT 19'h7_fff8
`define TKR_OFS_SEC 19'h7_fff9
`define TKR_OFS_MIN 19'h7_fffa
`define TKR_OFS_HOUR 19'h7_fffb
`define TKR_OFS_DAY 19'h7_fffc
`define TKR_OFS_DATE 19'h7_fffd
`define TKR_OFS_MON 19'h7_fffe
`define TKR_OFS_YEAR 19'h7_ffff
`define TKR_BIT_WRITE 7
`define TKR_BIT_READ 6
`define TKR_BIT_HALT 7
`define TKR_BIT_CELL 7
`define TKR_BIT_TEST 6
`define TKR_CLK_HZ 200000000
`define TKR_TEST_HZ 512
`define TKR_SEC_CYC (`TKR_CLK_HZ)
`define TKR_TEST_CYC (`TKR_CLK_HZ / (2 * `TKR_TEST_HZ))
`define TKR_HOLD_NS 5
`define TKR_CLK_NS 5
`define TKR_HOLD_CYC ((`TKR_HOLD_NS + `TKR_CLK_NS - 1) / `TKR_CLK_NS)
`endif

// ---- tkr_pkg.sv ----
// Types for the timekeeping RAM block
`default_nettype none
package tkr_pkg;
    typedef enum logic [2:0] {
        TKR_IDLE = 3'b001,
        TKR_READ = 3'b010,
        TKR_WRITE = 3'b100
    } tkr_bus_t;
    typedef logic [7:0] tkr_byte_t;
endpackage : tkr_pkg
`default_nettype wire

// ---- tkr_ram.sv ----
// Byte-wide storage array with registered read data
`default_nettype none
module tkr_ram #(
    parameter int DEPTH = 524288,
    parameter int AW = 19
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];
    // No reset: contents are meant to survive supply loss
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : tkr_ram
`default_nettype wire

// ---- tkr_rtc.sv ----
// Timekeeping RAM: byte bus, BCD clock registers, power-fail gating
`include "tkr_params.svh"
`default_nettype none
module tkr_rtc #(
    parameter int SEC_CYC = `TKR_SEC_CYC,
    parameter int TEST_CYC = `TKR_TEST_CYC,
    parameter int DEPTH = `TKR_RAM_DEPTH
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic [`TKR_ADDR_W-1:0] ADDR,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic [7:0] DQ_IN,
    output logic [7:0] DQ_OUT,
    output logic DQ_OE,
    input wire logic SUPPLY_FAIL,
    input wire logic CELL_OK,
    output logic RESET_OUT_N_OE,
    output logic BACKUP_EN
);
    import tkr_pkg::*;

    function automatic tkr_byte_t bcd_inc(input tkr_byte_t v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    function automatic tkr_byte_t month_len(input tkr_byte_t mo, input tkr_byte_t yr);
        logic leap;
        leap = ((yr[4] ? 1'b1 : 1'b0) ^ yr[1]) == 1'b0 && yr[0] == 1'b0;
        unique case (mo)
            8'h02: month_len = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction : month_len

    // Running counters (internal) and user-visible copies
    tkr_byte_t c_sec, c_min, c_hour, c_day, c_date, c_mon, c_year, c_cent;
    tkr_byte_t next_c_sec, next_c_min, next_c_hour, next_c_day;
    tkr_byte_t next_c_date, next_c_mon, next_c_year, next_c_cent;
    tkr_byte_t u_sec, u_min, u_hour, u_day, u_date, u_mon, u_year, u_cent;
    tkr_byte_t next_u_sec, next_u_min, next_u_hour, next_u_day;
    tkr_byte_t next_u_date, next_u_mon, next_u_year, next_u_cent;
    logic [31:0] tick_cnt, next_tick_cnt;
    logic [31:0] test_cnt, next_test_cnt;
    logic test_phase, next_test_phase;
    logic load_pend, next_load_pend;
    logic backup_on, next_backup_on;
    logic rst_oe, next_rst_oe;
    tkr_bus_t bus, next_bus;
    logic [`TKR_ADDR_W-1:0] addr_q, next_addr_q;
    logic [`TKR_HOLD_CYC:0] hold, next_hold;
    logic [7:0] dq, next_dq;
    logic dq_oe, next_dq_oe;
    logic [7:0] ram_rdata;
    logic ram_we;
    logic in_clk_regs;
    logic halted, frozen, writing, sec_tick;
    tkr_byte_t reg_rd;

    wire logic acc_ok = !SUPPLY_FAIL;
    wire logic wr_act = acc_ok && !CE_N && !WE_N;
    wire logic rd_act = acc_ok && !CE_N && !OE_N && WE_N;

    assign in_clk_regs = (ADDR >= `TKR_OFS_CENT);
    assign halted = c_sec[`TKR_BIT_HALT];
    assign writing = u_cent[`TKR_BIT_WRITE];
    assign frozen = u_cent[`TKR_BIT_READ] || writing;
    assign sec_tick = !halted && (tick_cnt == 32'(SEC_CYC - 1));
    // Spare bits kept on every write, no bit masked off
    assign ram_we = wr_act && !in_clk_regs;

    tkr_ram #(.DEPTH(DEPTH), .AW(`TKR_ADDR_W)) u_ram (
        .clk(CORE_CLK),
        .we(ram_we),
        .waddr(ADDR),
        .wdata(DQ_IN),
        .raddr(ADDR),
        .rdata(ram_rdata)
    );

    always_comb begin
        next_tick_cnt = tick_cnt;
        next_c_sec = c_sec;
        next_c_min = c_min;
        next_c_hour = c_hour;
        next_c_day = c_day;
        next_c_date = c_date;
        next_c_mon = c_mon;
        next_c_year = c_year;
        next_c_cent = c_cent;
        next_load_pend = load_pend;
        if (!halted) begin
            next_tick_cnt = sec_tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
        end
        // Counting has no dependence on supply state
        if (sec_tick) begin
            next_c_sec[6:0] = 7'(bcd_inc(c_sec));
            if (c_sec[6:0] == 7'h59) begin
                next_c_sec[6:0] = 7'h00;
                next_c_min[6:0] = 7'(bcd_inc(c_min));
                if (c_min[6:0] == 7'h59) begin
                    next_c_min[6:0] = 7'h00;
                    next_c_hour[5:0] = 6'(bcd_inc(c_hour));
                    if (c_hour[5:0] == 6'h23) begin
                        next_c_hour[5:0] = 6'h00;
                        next_c_day[2:0] = (c_day[2:0] == 3'h7) ? 3'h1 : c_day[2:0] + 3'h1;
                        next_c_date[5:0] = 6'(bcd_inc(c_date));
                        if (c_date[5:0] == 6'(month_len(c_mon & 8'h1f, c_year))) begin
                            next_c_date[5:0] = 6'h01;
                            next_c_mon[4:0] = 5'(bcd_inc(c_mon));
                            if (c_mon[4:0] == 5'h12) begin
                                next_c_mon[4:0] = 5'h01;
                                next_c_year = bcd_inc(c_year);
                                if (c_year == 8'h99) begin
                                    next_c_year = 8'h00;
                                    next_c_cent[5:0] = 6'(bcd_inc(c_cent));
                                    if (c_cent[5:0] == 6'h39) begin
                                        next_c_cent[5:0] = 6'h00;
                                    end
                                end
                            end
                        end
                    end
                end
            end
        end
        if (writing) begin
            next_load_pend = 1'b1;
        end else if (load_pend) begin
            next_load_pend = 1'b0;
            next_tick_cnt = 32'h0000_0000;
            next_c_sec = u_sec;
            next_c_min = u_min;
            next_c_hour = u_hour;
            next_c_day = u_day;
            next_c_date = u_date;
            next_c_mon = u_mon;
            next_c_year = u_year;
            next_c_cent = u_cent;
        end
        // Halt bit takes effect immediately, even when frozen
        if (wr_act && ADDR == `TKR_OFS_SEC) begin
            next_c_sec[`TKR_BIT_HALT] = DQ_IN[`TKR_BIT_HALT];
        end
    end

    always_comb begin
        next_u_sec = u_sec;
        next_u_min = u_min;
        next_u_hour = u_hour;
        next_u_day = u_day;
        next_u_date = u_date;
        next_u_mon = u_mon;
        next_u_year = u_year;
        next_u_cent = u_cent;
        if (!frozen && !load_pend) begin
            next_u_sec = c_sec;
            next_u_min = c_min;
            next_u_hour = c_hour;
            next_u_day = c_day;
            next_u_date = c_date;
            next_u_mon = c_mon;
            next_u_year = c_year;
            next_u_cent = {u_cent[7:6], c_cent[5:0]};
        end
        if (wr_act && in_clk_regs) begin
            unique case (ADDR)
                `TKR_OFS_CENT: next_u_cent = (DQ_IN[`TKR_BIT_WRITE] || writing) ?
                    DQ_IN : {DQ_IN[7:6], c_cent[5:0]};
                `TKR_OFS_SEC: next_u_sec = DQ_IN;
                `TKR_OFS_MIN: next_u_min = DQ_IN;
                `TKR_OFS_HOUR: next_u_hour = DQ_IN;
                `TKR_OFS_DAY: next_u_day = DQ_IN;
                `TKR_OFS_DATE: next_u_date = DQ_IN;
                `TKR_OFS_MON: next_u_mon = DQ_IN;
                default: next_u_year = DQ_IN;
            endcase
        end
    end

    always_comb begin
        next_test_cnt = 32'h0000_0000;
        next_test_phase = test_phase;
        if (u_day[`TKR_BIT_TEST] && !halted) begin
            next_test_cnt = (test_cnt == 32'(TEST_CYC - 1)) ? 32'h0000_0000 : test_cnt + 32'h0000_0001;
            if (test_cnt == 32'(TEST_CYC - 1)) begin
                next_test_phase = !test_phase;
            end
        end
    end

    // Register read mux
    always_comb begin
        unique case (addr_q)
            `TKR_OFS_CENT: reg_rd = u_cent;
            // Test phase shows on lowest data line
            `TKR_OFS_SEC: reg_rd = u_day[`TKR_BIT_TEST] ? {u_sec[7:1], test_phase} : u_sec;
            `TKR_OFS_MIN: reg_rd = u_min;
            `TKR_OFS_HOUR: reg_rd = u_hour;
            // Cell flag from monitor, never stored
            `TKR_OFS_DAY: reg_rd = {CELL_OK, u_day[6:0]};
            `TKR_OFS_DATE: reg_rd = u_date;
            `TKR_OFS_MON: reg_rd = u_mon;
            default: reg_rd = u_year;
        endcase
    end

    // Bus sequencing and data drive
    always_comb begin
        next_addr_q = ADDR;
        next_bus = TKR_IDLE;
        next_hold = '0;
        next_dq = dq;
        next_dq_oe = 1'b0;
        if (wr_act) begin
            next_bus = TKR_WRITE;
        end else if (rd_act) begin
            next_bus = TKR_READ;
        end
        if (rd_act) begin
            next_dq_oe = 1'b1;
            if (bus == TKR_READ && ADDR != addr_q) begin
                next_hold = {hold[`TKR_HOLD_CYC-1:0], 1'b1};
                next_dq = 8'hxx;
            end else begin
                next_dq = (addr_q >= `TKR_OFS_CENT) ? reg_rd : ram_rdata;
            end
        end
    end

    // Backup enabled at first good supply
    always_comb begin
        next_rst_oe = SUPPLY_FAIL;
        next_backup_on = backup_on || !SUPPLY_FAIL;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            tick_cnt <= 32'h0000_0000;
            test_cnt <= 32'h0000_0000;
            test_phase <= 1'b0;
            load_pend <= 1'b0;
            c_sec <= 8'h00; c_min <= 8'h00; c_hour <= 8'h00; c_day <= 8'h01;
            c_date <= 8'h01; c_mon <= 8'h01; c_year <= 8'h00; c_cent <= 8'h00;
            u_sec <= 8'h00; u_min <= 8'h00; u_hour <= 8'h00; u_day <= 8'h01;
            u_date <= 8'h01; u_mon <= 8'h01; u_year <= 8'h00; u_cent <= 8'h00;
            bus <= TKR_IDLE;
            addr_q <= '0;
            hold <= '0;
            dq <= 8'h00;
            dq_oe <= 1'b0;
            rst_oe <= 1'b1;
            backup_on <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            test_cnt <= next_test_cnt;
            test_phase <= next_test_phase;
            load_pend <= next_load_pend;
            c_sec <= next_c_sec; c_min <= next_c_min; c_hour <= next_c_hour;
            c_day <= next_c_day; c_date <= next_c_date; c_mon <= next_c_mon;
            c_year <= next_c_year; c_cent <= next_c_cent;
            u_sec <= next_u_sec; u_min <= next_u_min; u_hour <= next_u_hour;
            u_day <= next_u_day; u_date <= next_u_date; u_mon <= next_u_mon;
            u_year <= next_u_year; u_cent <= next_u_cent;
            bus <= next_bus;
            addr_q <= next_addr_q;
            hold <= next_hold;
            dq <= next_dq;
            dq_oe <= next_dq_oe;
            rst_oe <= next_rst_oe;
            backup_on <= next_backup_on;
        end
    end

    assign DQ_OUT = dq;
    assign DQ_OE = dq_oe;
    assign RESET_OUT_N_OE = rst_oe;
    assign BACKUP_EN = backup_on;
endmodule : tkr_rtc
`default_nettype wire

// ---- tkr_rtc_assertions.sv ----
// Bus, supply and backup checks on the timekeeping RAM ports
`include "tkr_params.svh"
`default_nettype none
module tkr_rtc_checker (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic [`TKR_ADDR_W-1:0] ADDR,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic [7:0] DQ_OUT,
    input wire logic DQ_OE,
    input wire logic SUPPLY_FAIL,
    input wire logic RESET_OUT_N_OE,
    input wire logic BACKUP_EN
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    logic rd;
    assign rd = !CE_N && !OE_N && WE_N && !SUPPLY_FAIL;
    sequence s_read_on;
        rd ##1 DQ_OE;
    endsequence
    // Clock registers may tick, so only plain storage must hold still
    sequence s_ram_steady;
        (rd && $stable(ADDR) && ADDR < `TKR_OFS_CENT) [*4];
    endsequence
    a_drive_needs_select: assert property (DQ_OE |-> !$past(CE_N) && !$past(OE_N))
        else $error("data driven without select and drive");
    a_read_enters: assert property (rd |=> DQ_OE)
        else $error("read request not driven");
    a_fail_blocks: assert property (SUPPLY_FAIL |=> !DQ_OE)
        else $error("data driven during supply fail");
    a_strobe_cuts: assert property (s_read_on ##1 !WE_N |=> !DQ_OE)
        else $error("falling strobe left outputs on");
    a_reset_follows: assert property (1'b1 |=> RESET_OUT_N_OE == $past(SUPPLY_FAIL))
        else $error("reset output does not track supply fail");
    a_backup_sticky: assert property (BACKUP_EN |=> BACKUP_EN)
        else $error("backup source dropped");
    a_backup_on: assert property (!SUPPLY_FAIL |=> BACKUP_EN)
        else $error("backup not enabled by good supply");
    a_ram_steady: assert property (s_ram_steady |-> $stable(DQ_OUT))
        else $error("read data moved with steady address");
endmodule : tkr_rtc_checker
bind tkr_rtc tkr_rtc_checker chk_u (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR), .CE_N(CE_N), .OE_N(OE_N),
    .WE_N(WE_N), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .SUPPLY_FAIL(SUPPLY_FAIL),
    .RESET_OUT_N_OE(RESET_OUT_N_OE), .BACKUP_EN(BACKUP_EN)
);
`default_nettype wire

// ---- tkr_host_model.sv ----
// Host processor model driving the byte-wide asynchronous bus
`include "tkr_params.svh"
`default_nettype none
module tkr_host_model (
    input wire logic clk,
    input wire tkr_pkg::tkr_byte_t dq_out,
    input wire logic dq_oe,
    output logic [`TKR_ADDR_W-1:0] addr,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output tkr_pkg::tkr_byte_t dq_in
);
    timeunit 1ns;
    timeprecision 100ps;
    import tkr_pkg::*;
    initial begin
        addr = '0;
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        dq_in = 8'h00;
    end
    task automatic do_write(input logic [`TKR_ADDR_W-1:0] a, input tkr_byte_t d,
        input logic rd_first);
        @(posedge clk);
        addr <= a;
        ce_n <= 1'b0;
        oe_n <= !rd_first;
        // read already driving when the strobe falls
        if (rd_first) repeat (2) @(posedge clk);
        we_n <= 1'b0;
        dq_in <= d;
        @(posedge clk);
        ce_n <= 1'b1;
        we_n <= 1'b1;
        oe_n <= 1'b1;
        // Released data lines must not look like the last value
        dq_in <= ~d;
        @(posedge clk);
    endtask : do_write
    // select returns high before the next cycle
    task automatic do_read(input logic [`TKR_ADDR_W-1:0] a, input int hold,
        output tkr_byte_t d, output logic drv);
        @(posedge clk);
        addr <= a;
        ce_n <= 1'b0;
        oe_n <= 1'b0;
        repeat (hold) @(posedge clk);
        #1;
        d = dq_out;
        drv = dq_oe;
        @(posedge clk);
        ce_n <= 1'b1;
        oe_n <= 1'b1;
    endtask : do_read
endmodule : tkr_host_model
`default_nettype wire

// ---- nv_timekeeping_ram_rtc_tb.sv ----
// Self-checking bench for the timekeeping RAM block
`include "tkr_params.svh"
`default_nettype none
module nv_timekeeping_ram_rtc_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import tkr_pkg::*;
    logic clk, resetn, supply_fail, cell_ok, ce_n, oe_n, we_n;
    logic dq_oe, rst_oe, backup_en, drv, prev_bit;
    logic [`TKR_ADDR_W-1:0] addr;
    tkr_byte_t dq_in, dq_out, d;
    int num_errors = 0;
    int total_checks = 0;
    int flips = 0;
    logic [`TKR_ADDR_W-1:0] regs [8] = '{`TKR_OFS_SEC, `TKR_OFS_MIN, `TKR_OFS_HOUR,
        `TKR_OFS_DAY, `TKR_OFS_DATE, `TKR_OFS_MON, `TKR_OFS_YEAR, `TKR_OFS_CENT};
    tkr_byte_t wvals [7] = '{8'h59, 8'hD9, 8'hE3, 8'h3B, 8'hF1, 8'hF2, 8'h99};
    tkr_byte_t rvals [7] = '{8'h59, 8'hD9, 8'hE3, 8'hBB, 8'hF1, 8'hF2, 8'h99};
    tkr_byte_t masks [8] = '{8'h7E, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F, 8'hFF, 8'hFF};
    tkr_byte_t rolled [8] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h01, 8'h00, 8'h41};
    // Short second and test periods keep the run brief
    tkr_rtc #(.SEC_CYC(20), .TEST_CYC(4), .DEPTH(`TKR_RAM_DEPTH)) dut_u (
        .CORE_CLK(clk), .RESETN(resetn), .ADDR(addr), .CE_N(ce_n), .OE_N(oe_n),
        .WE_N(we_n), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
        .SUPPLY_FAIL(supply_fail), .CELL_OK(cell_ok), .RESET_OUT_N_OE(rst_oe),
        .BACKUP_EN(backup_en));
    tkr_host_model host_u (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .addr(addr),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_in));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (dq_oe && dq_out[0] !== prev_bit) flips++;
        prev_bit <= dq_out[0];
    end
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask : check
    task automatic rd_chk(input logic [`TKR_ADDR_W-1:0] a, input tkr_byte_t m,
        input tkr_byte_t exp, input string name);
        host_u.do_read(a, 4, d, drv);
        check(name, exp, d & m);
    endtask : rd_chk
    task automatic watch_lsb();
        fork
            host_u.do_read(`TKR_OFS_SEC, 60, d, drv);
            begin
                repeat (8) @(posedge clk);
                #1 flips = 0;
            end
        join
    endtask : watch_lsb
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        resetn = 1'b0;
        supply_fail = 1'b1;
        cell_ok = 1'b1;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check("backup off", 8'h00, {7'h00, backup_en});
        check("reset out", 8'h01, {7'h00, rst_oe});
        @(posedge clk);
        supply_fail <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check("backup on", 8'h01, {7'h00, backup_en});
        check("reset out", 8'h00, {7'h00, rst_oe});
        host_u.do_write(19'h0_0010, 8'h3C, 1'b0);
        @(posedge clk);
        supply_fail <= 1'b1;
        host_u.do_write(19'h0_0010, 8'hA5, 1'b0);
        host_u.do_read(19'h0_0010, 4, d, drv);
        check("fail drive", 8'h00, {7'h00, drv});
        check("backup kept", 8'h01, {7'h00, backup_en});
        check("reset out", 8'h01, {7'h00, rst_oe});
        @(posedge clk);
        supply_fail <= 1'b0;
        rd_chk(19'h0_0010, 8'hFF, 8'h3C, "ram kept");
        host_u.do_write(19'h7_fff7, 8'h5A, 1'b1);
        rd_chk(19'h7_fff7, 8'hFF, 8'h5A, "ram top");
        host_u.do_write(`TKR_OFS_CENT, 8'h80, 1'b0);
        for (int i = 0; i < 7; i++) begin
            host_u.do_write(regs[i], wvals[i], 1'b0);
            rd_chk(regs[i], 8'hFF, rvals[i], "clock reg");
        end
        @(posedge clk);
        cell_ok <= 1'b0;
        rd_chk(`TKR_OFS_DAY, 8'hFF, 8'h3B, "cell low");
        cell_ok <= 1'b1;
        host_u.do_write(`TKR_OFS_CENT, 8'h00, 1'b0);
        repeat (30) @(posedge clk);
        host_u.do_write(`TKR_OFS_CENT, 8'h40, 1'b0);
        for (int i = 0; i < 8; i++) begin
            rd_chk(regs[i], masks[i], rolled[i], "rollover");
        end
        repeat (60) @(posedge clk);
        rd_chk(`TKR_OFS_SEC, 8'h7E, 8'h00, "frozen sec");
        host_u.do_write(`TKR_OFS_CENT, 8'h01, 1'b0);
        repeat (25) @(posedge clk);
        host_u.do_read(`TKR_OFS_SEC, 4, d, drv);
        check("sec moving", 8'h01, {7'h00, d > 8'h04});
        // Halt and test bit loaded in set mode so the stopped count is known
        host_u.do_write(`TKR_OFS_CENT, 8'h81, 1'b0);
        host_u.do_write(`TKR_OFS_SEC, 8'h80, 1'b0);
        host_u.do_write(`TKR_OFS_DAY, 8'h44, 1'b0);
        host_u.do_write(`TKR_OFS_CENT, 8'h01, 1'b0);
        repeat (50) @(posedge clk);
        rd_chk(`TKR_OFS_SEC, 8'hFF, 8'h80, "halted sec");
        host_u.do_write(`TKR_OFS_DAY, 8'h44, 1'b0);
        watch_lsb();
        check("halted flips", 8'h00, 8'(flips));
        host_u.do_write(`TKR_OFS_SEC, 8'h00, 1'b0);
        watch_lsb();
        check("test flips", 8'h01, {7'h00, flips >= 8});
        tally_and_finish();
    end
endmodule : nv_timekeeping_ram_rtc_tb
`default_nettype wire
